// *** two_wire_slave_ctrl.sv ***
// Operation
// R1 - Slave transmit byte answered by not-acknowledge reports C0h and sets interrupt flag.
// R2 - Last byte sent with acknowledge clear but acknowledged reports C8h.
// R3 - Leaving C0h/C8h with acknowledge clear: non-addressed, no address recognised.
// R4 - Leaving C0h/C8h with acknowledge set: own address, general call if enabled.
// R5 - Start request left set on exit: START generated once the bus is free.
// R6 - Interrupt flag zero and nothing relevant: status reads F8h.
// R7 - START or STOP in an illegal frame position reports 00h.
// R8 - Error recovery: stop request plus flag clear resets internally, releases bus.
// R9 - Rate bits sit at control bits 7, 1 and 0 and set bit rate.
// R10 - Control bit 6 enables the interface.
// R11 - Control bit 5 requests a START condition.
// R12 - Control bit 4 requests a STOP condition.
// R13 - Control bit 3 is set by hardware, cleared only by software.
// R14 - In receiver modes acknowledge-assert drives SDA low, else leaves it high.
// R15 - Acknowledge-assert gates own and general call address recognition.
// R16 - Acknowledge-assert has no effect in master transmitter mode.
// R17 - Status register holds code in bits 7..3, zeros below, resets F8h.
// R18 - Own-address bit 0 enables general call recognition.
// R19 - Status updates with the flag; bus is held until flag is cleared. Code releases SCL at once after 00h and A0h.
//
// Decided for this implementation: the APB register port.
`default_nettype none
module two_wire_slave_ctrl
  import two_wire_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Two-wire pins
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Interrupt
  output logic             irq
);

  control_t    ctrl_reg;
  logic [7:0]  status_reg;
  logic [7:0]  data_reg;
  logic [7:0]  own_addr_reg;
  logic [1:0]  irq_stat_reg;
  logic [1:0]  irq_stat_next;
  logic [1:0]  irq_mask_reg;
  logic        irq_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [1:0]  scl_sync_reg;
  logic [1:0]  sda_sync_reg;
  logic        scl_prev_reg;
  logic        sda_prev_reg;
  logic        pin_low_reg;
  fsm_t        state_reg;
  next_t       nxt_reg;
  logic [7:0]  shift_reg;
  logic [3:0]  bit_cnt_reg;
  logic [1:0]  phase_reg;
  logic [11:0] qcnt_reg;
  logic        last_byte_reg;
  logic        ack_en_reg;
  logic        ack_seen_reg;
  logic        gc_mode_reg;
  logic        busy_reg;
  logic        scl_oe_reg;
  logic        sda_oe_reg;
  logic        post_reg;
  logic [7:0]  post_code_reg;
  logic        sto_clr_reg;
  logic        rx_load_reg;

  // Pin synchronisers and bus condition detection
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  wire scl_s     = scl_sync_reg[1];
  wire sda_s     = sda_sync_reg[1];
  wire scl_rise  = scl_s & ~scl_prev_reg;
  wire scl_fall  = ~scl_s & scl_prev_reg;
  wire start_det = scl_s & scl_prev_reg & ~sda_s & sda_prev_reg;
  wire stop_det  = scl_s & scl_prev_reg & sda_s & ~sda_prev_reg;

  // APB decode
  wire access     = psel & penable & pready_reg;
  wire wr         = access & pwrite;
  wire rd         = access & ~pwrite;
  wire hit_ctrl   = paddr == ADDR_CONTROL;
  wire hit_status = paddr == ADDR_STATUS;
  wire hit_data   = paddr == ADDR_DATA;
  wire hit_own    = paddr == ADDR_OWN_ADDR;
  wire hit_istat  = paddr == ADDR_IRQ_STATUS;
  wire hit_imask  = paddr == ADDR_IRQ_MASK;
  wire mapped     = hit_ctrl | hit_status | hit_data | hit_own | hit_istat | hit_imask;
  wire [7:0] rd_mux = hit_ctrl   ? ctrl_reg :
                      hit_status ? status_reg :
                      hit_data   ? data_reg :
                      hit_own    ? own_addr_reg :
                      hit_istat  ? {6'h00, irq_stat_reg} :
                      hit_imask  ? {6'h00, irq_mask_reg} : 8'h00;
  wire control_t wr_ctrl_val = control_t'(pwdata[7:0]);

  // Zero wait state answer, read data captured in the setup cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= psel & ~penable & ~pready_reg;
      pslverr_reg <= psel & ~penable & ~pready_reg & ~mapped;
      if (psel & ~penable & ~pwrite) begin
        prdata_reg <= {24'h00_0000, rd_mux};
      end
    end
  end

  // Address recognition
  wire rw_bit  = shift_reg[0];
  wire own_hit = ctrl_reg.acknowledge_assert && (shift_reg[7:1] == own_addr_reg[7:1]); // see R15
  wire gc_hit  = ctrl_reg.acknowledge_assert && own_addr_reg[0] && !rw_bit
                 && (shift_reg == GC_ADDRESS); // see R18
  wire in_bits = (state_reg == S_ADDR) || (state_reg == S_TX) || (state_reg == S_RX);
  wire in_ack  = (state_reg == S_ADDR_ACK) || (state_reg == S_TX_ACK)
                 || (state_reg == S_RX_ACK);
  // A condition right after the first rise of a byte sits on the byte boundary
  wire [3:0] legal_cnt = (state_reg == S_TX) ? 4'd0 : 4'd1;
  wire frame_err = (start_det | stop_det)
                   && ((in_bits && bit_cnt_reg > legal_cnt) || in_ack); // see R7
  wire si_clear  = !post_reg && !ctrl_reg.int_flag;

  // Quarter bit timer for generated conditions
  wire [2:0]  rate_sel    = {ctrl_reg.rate_bit_2, ctrl_reg.rate_bit_1, ctrl_reg.rate_bit_0};
  wire [11:0] qreload     = QUARTER_CYC << rate_sel; // see R9
  wire        master_run  = (state_reg == S_MSTART) || (state_reg == S_MSTOP);
  wire        tick        = master_run && (qcnt_reg == 12'h000);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      qcnt_reg <= 12'h000;
    end else if (!master_run || tick) begin
      qcnt_reg <= qreload - 12'h001; // Tick every qreload cycles
    end else begin
      qcnt_reg <= qcnt_reg - 12'h001;
    end
  end

  // Main bus state machine
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg     <= S_IDLE;
      nxt_reg       <= NXT_END;
      shift_reg     <= 8'h00;
      bit_cnt_reg   <= 4'h0;
      phase_reg     <= 2'h0;
      last_byte_reg <= 1'b0;
      ack_en_reg    <= 1'b0;
      ack_seen_reg  <= 1'b0;
      gc_mode_reg   <= 1'b0;
      busy_reg      <= 1'b0;
      scl_oe_reg    <= 1'b0;
      sda_oe_reg    <= 1'b0;
      post_reg      <= 1'b0;
      post_code_reg <= ST_NONE;
      sto_clr_reg   <= 1'b0;
      rx_load_reg   <= 1'b0;
    end else begin
      post_reg    <= 1'b0;
      sto_clr_reg <= 1'b0;
      rx_load_reg <= 1'b0;
      if (start_det) begin
        busy_reg <= 1'b1;
      end else if (stop_det) begin
        busy_reg <= 1'b0;
      end
      if (!ctrl_reg.interface_enable) begin // see R10
        state_reg  <= S_IDLE;
        scl_oe_reg <= 1'b0;
        sda_oe_reg <= 1'b0;
      end else if (frame_err) begin // see R7
        state_reg     <= S_ERR;
        scl_oe_reg    <= 1'b0;
        sda_oe_reg    <= 1'b0;
        post_reg      <= 1'b1;
        post_code_reg <= ST_BUS_ERR;
      end else begin
        case (state_reg)
          S_IDLE: begin
            if (start_det) begin
              state_reg   <= S_ADDR;
              bit_cnt_reg <= 4'h0;
            end else if (ctrl_reg.start_request && !busy_reg && si_clear) begin // see R5, R11
              state_reg  <= S_MSTART;
              sda_oe_reg <= 1'b1;
              phase_reg  <= 2'h0;
            end
          end
          S_ADDR: begin
            if (start_det) begin
              bit_cnt_reg <= 4'h0;
            end else if (stop_det) begin
              state_reg <= S_IDLE;
            end else if (scl_rise) begin
              shift_reg   <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'd8) begin
              gc_mode_reg <= gc_hit & ~own_hit;
              if (own_hit || gc_hit) begin // see R15
                sda_oe_reg <= 1'b1;
                state_reg  <= S_ADDR_ACK;
              end else begin
                state_reg <= S_IDLE;
              end
            end
          end
          S_ADDR_ACK: begin
            if (scl_fall) begin
              sda_oe_reg    <= 1'b0;
              scl_oe_reg    <= 1'b1;
              post_reg      <= 1'b1;
              post_code_reg <= rw_bit ? ST_SLA_R : (gc_mode_reg ? ST_GC_W : ST_SLA_W);
              nxt_reg       <= rw_bit ? NXT_TX : NXT_RX;
              state_reg     <= S_HOLD;
            end
          end
          S_HOLD: begin
            if (si_clear) begin // see R19
              scl_oe_reg  <= 1'b0;
              bit_cnt_reg <= 4'h0;
              case (nxt_reg)
                NXT_TX: begin
                  shift_reg     <= data_reg;
                  sda_oe_reg    <= ~data_reg[7];
                  last_byte_reg <= ~ctrl_reg.acknowledge_assert;
                  state_reg     <= S_TX;
                end
                NXT_RX: begin
                  ack_en_reg <= ctrl_reg.acknowledge_assert;
                  state_reg  <= S_RX;
                end
                default: begin
                  state_reg <= S_IDLE; // see R3, R4
                end
              endcase
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (bit_cnt_reg == 4'd7) begin
                sda_oe_reg <= 1'b0;
                state_reg  <= S_TX_ACK;
              end else begin
                shift_reg   <= {shift_reg[6:0], 1'b0};
                sda_oe_reg  <= ~shift_reg[6];
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          S_TX_ACK: begin
            if (scl_rise) begin
              ack_seen_reg <= ~sda_s;
            end else if (scl_fall) begin
              scl_oe_reg    <= 1'b1;
              post_reg      <= 1'b1;
              post_code_reg <= !ack_seen_reg ? ST_TX_NACK :
                               (last_byte_reg ? ST_TX_LAST : ST_TX_ACKED); // see R1, R2
              nxt_reg       <= (!ack_seen_reg || last_byte_reg) ? NXT_END : NXT_TX;
              state_reg     <= S_HOLD;
            end
          end
          S_RX: begin
            if ((stop_det || start_det) && bit_cnt_reg <= 4'd1) begin
              post_reg      <= 1'b1;
              post_code_reg <= ST_STOP_RX;
              bit_cnt_reg   <= 4'h0;
              state_reg     <= start_det ? S_ADDR : S_IDLE;
            end else if (scl_rise) begin
              shift_reg   <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'd8) begin
              sda_oe_reg  <= ack_en_reg; // see R14
              rx_load_reg <= 1'b1;
              state_reg   <= S_RX_ACK;
            end
          end
          S_RX_ACK: begin
            if (scl_fall) begin
              sda_oe_reg    <= 1'b0;
              scl_oe_reg    <= 1'b1;
              post_reg      <= 1'b1;
              post_code_reg <= gc_mode_reg ? (ack_en_reg ? ST_GC_ACK : ST_GC_NACK)
                                           : (ack_en_reg ? ST_RX_ACK : ST_RX_NACK);
              nxt_reg       <= ack_en_reg ? NXT_RX : NXT_END;
              state_reg     <= S_HOLD;
            end
          end
          S_ERR: begin
            if (si_clear) begin
              sto_clr_reg <= ctrl_reg.stop_request; // see R8
              state_reg   <= S_IDLE;
            end
          end
          S_MSTART: begin
            if (tick) begin
              phase_reg <= phase_reg + 2'h1;
              if (phase_reg == 2'h1) begin
                scl_oe_reg    <= 1'b1; // see R11
                post_reg      <= 1'b1;
                post_code_reg <= ST_M_START;
                state_reg     <= S_MHOLD;
              end
            end
          end
          S_MHOLD: begin
            if (si_clear) begin // see R16
              phase_reg <= 2'h0;
              if (ctrl_reg.stop_request) begin
                state_reg <= S_MSTOP; // see R12
              end else begin
                scl_oe_reg <= 1'b0;
                sda_oe_reg <= 1'b0;
                state_reg  <= S_IDLE;
              end
            end
          end
          S_MSTOP: begin
            if (tick) begin
              phase_reg <= phase_reg + 2'h1;
              if (phase_reg == 2'h0) begin
                scl_oe_reg <= 1'b0;
              end else if (phase_reg == MSTOP_LAST) begin
                sda_oe_reg  <= 1'b0; // see R12
                sto_clr_reg <= 1'b1;
                state_reg   <= S_IDLE;
              end
            end
          end
          default: begin
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end

  // Control register; hardware set of the flag wins over a software clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_reg <= control_t'(CONTROL_RESET);
    end else begin
      if (wr && hit_ctrl) begin
        ctrl_reg          <= wr_ctrl_val;
        ctrl_reg.int_flag <= ctrl_reg.int_flag & wr_ctrl_val.int_flag; // see R13
      end
      if (sto_clr_reg) begin
        ctrl_reg.stop_request <= 1'b0; // see R8
      end
      if (post_reg) begin
        ctrl_reg.int_flag <= 1'b1; // see R13
      end
    end
  end

  // Status code moves with the flag and returns to F8h once it clears
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_reg <= STATUS_RESET; // see R17
    end else if (post_reg) begin
      status_reg <= post_code_reg; // see R19
    end else if (!ctrl_reg.int_flag) begin
      status_reg <= ST_NONE; // see R6
    end
  end

  // Data and own address registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_reg     <= DATA_RESET;
      own_addr_reg <= OWN_ADDR_RESET;
    end else begin
      if (rx_load_reg) begin
        data_reg <= shift_reg;
      end else if (wr && hit_data) begin
        data_reg <= pwdata[7:0];
      end
      if (wr && hit_own) begin
        own_addr_reg <= pwdata[7:0];
      end
    end
  end

  // Interrupt status: read clears reported bits, new events win
  wire [1:0] irq_events = {post_reg && post_code_reg == ST_BUS_ERR, post_reg};
  wire [1:0] irq_rd_clr = (rd && hit_istat) ? prdata_reg[1:0] : 2'b00;
  assign irq_stat_next = (irq_stat_reg & ~irq_rd_clr) | irq_events;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_stat_reg <= IRQ_RESET;
      irq_mask_reg <= IRQ_RESET;
      irq_reg      <= 1'b0;
      pin_low_reg  <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (wr && hit_imask) begin
        irq_mask_reg <= pwdata[1:0];
      end
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Outputs
  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign scl_out = pin_low_reg;
  assign sda_out = pin_low_reg;
  assign scl_oe  = scl_oe_reg;
  assign sda_oe  = sda_oe_reg;
  assign irq     = irq_reg;

  // Checks
  tx_nack_a: assert property (@(posedge clock) disable iff (rst) // see R1
    (state_reg == S_TX_ACK && scl_fall && !ack_seen_reg && !frame_err
     && ctrl_reg.interface_enable) |-> ##2 (status_reg == ST_TX_NACK && ctrl_reg.int_flag))
    else $error("not-acknowledge did not report C0h");
  tx_last_a: assert property (@(posedge clock) disable iff (rst) // see R2
    (state_reg == S_TX_ACK && scl_fall && ack_seen_reg && last_byte_reg && !frame_err
     && ctrl_reg.interface_enable) |-> ##2 (status_reg == ST_TX_LAST))
    else $error("last byte acknowledged did not report C8h");
  end_release_a: assert property (@(posedge clock) disable iff (rst) // see R3
    (state_reg == S_HOLD && nxt_reg == NXT_END && si_clear && !frame_err
     && ctrl_reg.interface_enable) |=> (state_reg == S_IDLE && !scl_oe_reg))
    else $error("slave did not leave addressed mode");
  no_recog_a: assert property (@(posedge clock) disable iff (rst) // see R15
    (state_reg == S_ADDR && !ctrl_reg.acknowledge_assert) |=> !sda_oe_reg)
    else $error("address acknowledged with acknowledge-assert clear");
  idle_code_a: assert property (@(posedge clock) disable iff (rst) // see R6
    (!ctrl_reg.int_flag && !post_reg && !$past(post_reg)) |=> status_reg == ST_NONE)
    else $error("status not F8h with flag clear");
  bus_err_a: assert property (@(posedge clock) disable iff (rst) // see R7
    (frame_err && ctrl_reg.interface_enable)
    |-> ##2 (status_reg == ST_BUS_ERR && ctrl_reg.int_flag && !scl_oe_reg))
    else $error("illegal condition did not report 00h");
  err_recover_a: assert property (@(posedge clock) disable iff (rst) // see R8
    (state_reg == S_ERR && si_clear && ctrl_reg.stop_request && ctrl_reg.interface_enable
     && !(wr && hit_ctrl)) |-> ##2 (!ctrl_reg.stop_request && !sda_oe_reg && !scl_oe_reg))
    else $error("bus error recovery failed");
  hold_bus_a: assert property (@(posedge clock) disable iff (rst) // see R19
    (state_reg == S_HOLD && ctrl_reg.int_flag) |-> scl_oe_reg)
    else $error("clock released while flag set");
  rx_ack_a: assert property (@(posedge clock) disable iff (rst) // see R14
    (state_reg == S_RX_ACK && !scl_fall) |-> (sda_oe_reg == ack_en_reg))
    else $error("receiver acknowledge not driven as configured");
  start_gen_a: assert property (@(posedge clock) disable iff (rst) // see R5
    (state_reg == S_IDLE && ctrl_reg.start_request && !busy_reg && si_clear && !start_det
     && ctrl_reg.interface_enable) |=> (state_reg == S_MSTART && sda_oe_reg))
    else $error("START not begun on a free bus");

endmodule : two_wire_slave_ctrl
`default_nettype wire

// *** two_wire_pkg.sv ***
`default_nettype none
package two_wire_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0]  IDX_CONTROL    = 8'h93;
  localparam logic [7:0]  IDX_STATUS     = 8'h94;
  localparam logic [7:0]  IDX_DATA       = 8'h95;
  localparam logic [7:0]  IDX_OWN_ADDR   = 8'h96;
  localparam logic [7:0]  IDX_IRQ_STATUS = 8'h97;
  localparam logic [7:0]  IDX_IRQ_MASK   = 8'h98;
  localparam logic [11:0] ADDR_CONTROL    = {2'b00, IDX_CONTROL, 2'b00};
  localparam logic [11:0] ADDR_STATUS     = {2'b00, IDX_STATUS, 2'b00};
  localparam logic [11:0] ADDR_DATA       = {2'b00, IDX_DATA, 2'b00};
  localparam logic [11:0] ADDR_OWN_ADDR   = {2'b00, IDX_OWN_ADDR, 2'b00};
  localparam logic [11:0] ADDR_IRQ_STATUS = {2'b00, IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] ADDR_IRQ_MASK   = {2'b00, IDX_IRQ_MASK, 2'b00};

  // Reset values
  localparam logic [7:0] CONTROL_RESET  = 8'h00;
  localparam logic [7:0] STATUS_RESET   = 8'hf8;
  localparam logic [7:0] DATA_RESET     = 8'h00;
  localparam logic [7:0] OWN_ADDR_RESET = 8'hfe;
  localparam logic [1:0] IRQ_RESET      = 2'h0;

  // Status codes (code in bits 7..3, bits 2..0 always zero)
  localparam logic [7:0] ST_NONE     = 8'hf8;
  localparam logic [7:0] ST_BUS_ERR  = 8'h00;
  localparam logic [7:0] ST_M_START  = 8'h08;
  localparam logic [7:0] ST_SLA_W    = 8'h60;
  localparam logic [7:0] ST_GC_W     = 8'h70;
  localparam logic [7:0] ST_RX_ACK   = 8'h80;
  localparam logic [7:0] ST_RX_NACK  = 8'h88;
  localparam logic [7:0] ST_GC_ACK   = 8'h90;
  localparam logic [7:0] ST_GC_NACK  = 8'h98;
  localparam logic [7:0] ST_STOP_RX  = 8'ha0;
  localparam logic [7:0] ST_SLA_R    = 8'ha8;
  localparam logic [7:0] ST_TX_ACKED = 8'hb8;
  localparam logic [7:0] ST_TX_NACK  = 8'hc0;
  localparam logic [7:0] ST_TX_LAST  = 8'hc8;
  localparam logic [7:0] GC_ADDRESS  = 8'h00;

  // Interrupt status bit positions
  localparam int IRQ_SI_BIT  = 0;
  localparam int IRQ_ERR_BIT = 1;

  // Quarter bit time of the generated START/STOP at rate zero
  localparam int          CLOCK_NS    = 25;
  localparam int          QUARTER_NS  = 625;
  localparam logic [11:0] QUARTER_CYC = 12'((QUARTER_NS + CLOCK_NS - 1) / CLOCK_NS);
  localparam logic [1:0]  MSTOP_LAST  = 2'd2;

  // Control register layout, bit 7 first
  typedef struct packed {
    logic rate_bit_2;
    logic interface_enable;
    logic start_request;
    logic stop_request;
    logic int_flag;
    logic acknowledge_assert;
    logic rate_bit_1;
    logic rate_bit_0;
  } control_t;

  typedef enum logic [3:0] {
    S_IDLE     = 4'b0000,
    S_ADDR     = 4'b0001,
    S_ADDR_ACK = 4'b0011,
    S_HOLD     = 4'b0010,
    S_TX       = 4'b0110,
    S_TX_ACK   = 4'b0111,
    S_RX       = 4'b0101,
    S_RX_ACK   = 4'b0100,
    S_ERR      = 4'b1100,
    S_MSTART   = 4'b1101,
    S_MHOLD    = 4'b1111,
    S_MSTOP    = 4'b1110
  } fsm_t;

  typedef enum logic [1:0] {
    NXT_TX  = 2'b00,
    NXT_RX  = 2'b01,
    NXT_END = 2'b11
  } next_t;

endpackage : two_wire_pkg
`default_nettype wire

// *** two_wire_master_model.sv ***
`default_nettype none
// Far-side bus master; open drain, wires pulled up
module two_wire_master_model (
  input  wire logic clock,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_oe,
  output logic      sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // Quarter of a 200 ns bit
  task automatic q;
    repeat (2) @(posedge clock);
  endtask : q
  // Release SCL and wait out any stretch
  task automatic rise;
    scl_oe <= 1'b0;
    q();
    while (!scl) @(posedge clock);
  endtask : rise
  task automatic start;
    sda_oe <= 1'b1;
    q();
    scl_oe <= 1'b1;
    q();
  endtask : start
  task automatic stop;
    sda_oe <= 1'b1;
    q();
    rise();
    sda_oe <= 1'b0;
    q();
  endtask : stop
  // One bit out, wire level back
  task automatic bit_io(input logic b, output logic r);
    sda_oe <= !b;
    q();
    rise();
    r = sda;
    q();
    scl_oe <= 1'b1;
    q();
  endtask : bit_io
  // Byte MSB first, then the ninth bit
  task automatic xfer(input logic [7:0] d, input logic a,
                      output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(a, k);
  endtask : xfer
endmodule : two_wire_master_model
`default_nettype wire

// *** tb_two_wire_slave_tx_end_and_control.sv ***
`default_nettype none
module tb_two_wire_slave_tx_end_and_control
  import two_wire_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        scl_oe, sda_oe, m_scl_oe, m_sda_oe, ak, b;
  logic [7:0]  d, r;
  logic [8:0]  exp_q[$];
  int          seed, mismatches, checks_done;
  wire         scl = !(scl_oe | m_scl_oe);
  wire         sda = !(sda_oe | m_sda_oe);
  two_wire_slave_ctrl dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda),
    .sda_out(), .sda_oe(sda_oe), .irq(irq));
  two_wire_master_model m (.clock(clock), .scl(scl), .sda(sda), .scl_oe(m_scl_oe),
    .sda_oe(m_sda_oe));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = !clock;
  end
  task automatic check(input string n, input logic [8:0] e, input logic [8:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : check
  // APB transfer; a read notes its expected {pslverr, data}
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v,
                     input logic [8:0] e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, v};
    @(posedge clock);
    penable <= 1'b1;
    if (!w) exp_q.push_back(e);
    do @(posedge clock); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    apb(1'b1, a, v, 9'h000);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00, {1'b0, e});
  endtask : rd
  task automatic wait_irq;
    for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge clock);
    check("irq", 9'h001, {8'h00, irq});
  endtask : wait_irq
  // Read results taken off the queue as they appear
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      check("prdata", exp_q.pop_front(), {pslverr, prdata[7:0]});
      check("prdata hi", 9'h000, {1'b0, prdata[31:24] | prdata[23:16] | prdata[15:8]});
    end
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  // Watchdog
  initial begin
    repeat (60000) @(posedge clock);
    mismatches++;
    conclude();
  end
  // Main sequence
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = '0;
    rst = 1'b1;
    seed = 86505;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    rd(ADDR_STATUS, STATUS_RESET);
    rd(ADDR_CONTROL, CONTROL_RESET);
    rd(ADDR_OWN_ADDR, OWN_ADDR_RESET);
    apb(1'b0, 12'hffc, 8'h00, 9'h100);
    wr(ADDR_OWN_ADDR, 8'ha0);
    wr(ADDR_IRQ_MASK, 8'h01);
    wr(ADDR_CONTROL, 8'h44);
    m.start();
    m.xfer(GC_ADDRESS, 1'b1, r, ak);
    check("gc off nack", 9'h001, {8'h00, ak});
    m.stop();
    wr(ADDR_OWN_ADDR, 8'ha1);
    // Slave transmit ends: acked last byte, then not-acknowledged byte
    for (int k = 0; k < 2; k++) begin
      d = 8'($random(seed));
      m.start();
      m.xfer(8'ha1, 1'b1, r, ak);
      check("sla ack", 9'h000, {8'h00, ak});
      wait_irq();
      rd(ADDR_STATUS, ST_SLA_R);
      rd(ADDR_IRQ_STATUS, 8'h01);
      wr(ADDR_DATA, d);
      wr(ADDR_CONTROL, 8'h40);
      m.xfer(8'hff, 1'(k), r, ak);
      check("tx byte", {1'b0, d}, {1'b0, r});
      wait_irq();
      rd(ADDR_STATUS, k ? ST_TX_NACK : ST_TX_LAST);
      rd(ADDR_CONTROL, 8'h48);
      rd(ADDR_IRQ_STATUS, 8'h01);
      wr(ADDR_CONTROL, 8'h40);
      m.stop();
      rd(ADDR_STATUS, ST_NONE);
      m.start();
      m.xfer(8'ha1, 1'b1, r, ak);
      check("ignored", 9'h001, {8'h00, ak});
      m.stop();
      wr(ADDR_CONTROL, 8'h44);
    end
    // Slave receive: byte acknowledged, then STOP at the byte boundary
    m.start();
    m.xfer(8'ha0, 1'b1, r, ak);
    wait_irq();
    rd(ADDR_STATUS, ST_SLA_W);
    rd(ADDR_IRQ_STATUS, 8'h01);
    wr(ADDR_CONTROL, 8'h44);
    m.xfer(d, 1'b1, r, ak);
    check("rx ack", 9'h000, {8'h00, ak});
    wait_irq();
    rd(ADDR_STATUS, ST_RX_ACK);
    rd(ADDR_DATA, d);
    rd(ADDR_IRQ_STATUS, 8'h01);
    wr(ADDR_CONTROL, 8'h40);
    m.stop();
    wait_irq();
    rd(ADDR_STATUS, ST_STOP_RX);
    rd(ADDR_IRQ_STATUS, 8'h01);
    wr(ADDR_CONTROL, 8'h44);
    // STOP in mid address is a bus error
    m.start();
    m.bit_io(1'b1, b);
    m.bit_io(1'b0, b);
    m.stop();
    wait_irq();
    rd(ADDR_STATUS, ST_BUS_ERR);
    rd(ADDR_IRQ_STATUS, 8'h03);
    wr(ADDR_CONTROL, 8'h54);
    repeat (4) @(posedge clock);
    rd(ADDR_CONTROL, 8'h44);
    rd(ADDR_STATUS, ST_NONE);
    check("err scl free", 9'h001, {8'h00, scl});
    // Master START, then STOP
    wr(ADDR_CONTROL, 8'h64);
    wait_irq();
    check("start sda", 9'h000, {8'h00, sda});
    rd(ADDR_STATUS, ST_M_START);
    rd(ADDR_IRQ_STATUS, 8'h01);
    wr(ADDR_CONTROL, 8'h54);
    repeat (150) @(posedge clock);
    check("stop lines", 9'h003, {7'h00, scl, sda});
    rd(ADDR_CONTROL, 8'h44);
    repeat (3) @(posedge clock);
    conclude();
  end
endmodule : tb_two_wire_slave_tx_end_and_control
`default_nettype wire
